// file: rtl/accum_timer_pkg.sv
// Shared constants for the capture registers and pulse accumulator control
package accum_timer_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] TSC_OFFSET       = 8'h00;
    localparam logic [7:0] FUNC_SEL_OFFSET  = 8'h04;
    localparam logic [7:0] ACC_CTRL_OFFSET  = 8'h20;
    localparam logic [7:0] ACC_FLAG_OFFSET  = 8'h24;
    localparam logic [7:0] ACC_COUNT_OFFSET = 8'h28;
    localparam logic [7:0] CH_VAL_BASE      = 8'h40;
    localparam logic [7:0] CH_VAL_LAST      = 8'h5c;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TIMER_EN_BIT = 7;
    localparam int ACC_EN_BIT   = 6;
    localparam int MODE_BIT     = 5;
    localparam int POL_BIT      = 4;
    localparam int CLK_SEL_HI   = 3;
    localparam int CLK_SEL_LO   = 2;
    localparam int OVF_IE_BIT   = 1;
    localparam int IN_IE_BIT    = 0;
    localparam int OVF_FLAG_BIT = 1;
    localparam int IN_FLAG_BIT  = 0;

    // ------------------------------------------------------------------
    // Reset values, masks and encodings
    // ------------------------------------------------------------------
    localparam logic [7:0]  ACC_CTRL_RST  = 8'h00;
    localparam logic [7:0]  ACC_CTRL_MASK = 8'h7f;
    localparam logic [15:0] CH_VAL_RST    = 16'h0000;
    localparam logic [15:0] ACC_MAX       = 16'hffff;
    localparam logic [1:0]  CLK_PRESCALER = 2'h0;
    localparam logic [1:0]  CLK_ACC       = 2'h1;
    localparam logic [1:0]  CLK_ACC_256   = 2'h2;
    localparam logic [1:0]  CLK_ACC_64K   = 2'h3;
    localparam int          NUM_CH        = 8;

    // ------------------------------------------------------------------
    // Divider widths: 64, 256 and 65536
    // ------------------------------------------------------------------
    localparam int DIV64_W  = 6;
    localparam int DIV256_W = 8;
    localparam int DIV64K_W = 16;

endpackage : accum_timer_pkg

// file: rtl/pin_sync_edge.sv
// Two-stage synchroniser with level and edge outputs for the shared pin
`timescale 1ns/1ps
module pin_sync_edge (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_t;

    sync_t sync_ff;
    sync_t nxt_sync;

    // ------------------------------------------------------------------
    // Stage shift; only s2 and s3 feed the edge logic, s1 may be metastable
    // ------------------------------------------------------------------
    always_comb begin
        nxt_sync    = sync_ff;
        nxt_sync.s1 = pin_in;
        nxt_sync.s2 = sync_ff.s1;
        nxt_sync.s3 = sync_ff.s2;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    // Edges compare the settled stage with its delayed copy
    assign level = sync_ff.s2;
    assign rise  = sync_ff.s2 && !sync_ff.s3;
    assign fall  = !sync_ff.s2 && sync_ff.s3;

endmodule : pin_sync_edge

// file: rtl/tick_divider.sv
// Tick divider: one output pulse per 2**W input ticks while running
`timescale 1ns/1ps
module tick_divider #(
    parameter int W = 6
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic tick_in,
    input  wire logic run,
    output logic      tick_out
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         out;
    } div_state_t;

    div_state_t div_ff;
    div_state_t nxt_div;

    // ------------------------------------------------------------------
    // Count; stopping clears the phase so a restart is a full period
    // ------------------------------------------------------------------
    always_comb begin
        nxt_div     = div_ff;
        nxt_div.out = run && tick_in && (&div_ff.cnt);
        if (!run) begin
            nxt_div.cnt = '0;
        end else if (tick_in) begin
            nxt_div.cnt = div_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    assign tick_out = div_ff.out;

endmodule : tick_divider

// file: rtl/accum_capture_top.sv
// Channel capture/compare values and pulse accumulator control, AHB-Lite slave
//
// Contract
// - Channel captures counter or holds compare value
// - Writes only in compare mode; reads always
// - Channel values clear to zero on reset
// - Enable bit six runs accumulator without timer
// - Accumulator input is channel seven pin
// - Bit five: event or gated mode
// - Event mode: bit four picks counted edge
// - Gated mode: level gates div64, trailing edge flags
// - No div64 clock while timer disabled
// - Bits 3:2 pick timer counter clock
// - Accumulator off: prescaler clock always used
// - Clock select change takes effect immediately
// - Bit one enables overflow interrupt request
// - Bit zero enables input edge request
// - Control register at 0x20, read/write anytime
// - Count wrap from maximum sets overflow flag
// - Event mode selected edge sets input flag
`timescale 1ns/1ps
module accum_capture_top
    import accum_timer_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        channel7_pin,
    input  wire logic [15:0] free_count,
    input  wire logic [7:0]  capture_strobe,
    input  wire logic        prescaler_tick,
    output logic             timer_count_tick,
    output logic      [7:0]  compare_match,
    output logic             timer_enable,
    output logic             ovf_irq_req,
    output logic             input_irq_req
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]        acc_ctrl;
        logic              timer_en;
        logic [7:0]        func_sel;
        logic [7:0][15:0]  ch_val;
        logic [15:0]       acc_count;
        logic              ovf_flag;
        logic              in_flag;
        logic              dp_valid;
        logic              dp_write;
        logic [7:0]        dp_addr;
        logic [31:0]       rdata;
        logic              ready;
        logic              resp;
        logic              cnt_tick;
        logic [7:0]        match;
        logic              ovf_irq;
        logic              in_irq;
    } state_t;

    // Channel values reset through the default to CH_VAL_RST (zero)
    localparam state_t RST_STATE = '{acc_ctrl: ACC_CTRL_RST, ready: 1'b1, default: '0};

    state_t st_ff;
    state_t nxt_st;

    logic pin_level;
    logic pin_rise;
    logic pin_fall;
    logic div64_tick;
    logic div256_tick;
    logic div64k_tick;
    logic accumulator_enable;
    logic gated_mode;
    logic pol;
    logic sel_edge;
    logic gate_open;
    logic acc_inc;
    logic addr_take;
    logic [1:0] clk_sel;

    // ------------------------------------------------------------------
    // Address decode helpers
    // ------------------------------------------------------------------
    function automatic logic is_ch_addr(input logic [7:0] a);
        return (a >= CH_VAL_BASE) && (a <= CH_VAL_LAST) && (a[1:0] == 2'h0);
    endfunction : is_ch_addr

    function automatic logic [2:0] ch_idx(input logic [7:0] a);
        logic [7:0] off;
        off = a - CH_VAL_BASE;
        return off[4:2];
    endfunction : ch_idx

    function automatic logic [31:0] read_word(input state_t s, input logic [7:0] a);
        logic [31:0] w;
        w = '0;
        if (a == TSC_OFFSET) begin
            w[TIMER_EN_BIT] = s.timer_en;
        end else if (a == FUNC_SEL_OFFSET) begin
            w[7:0] = s.func_sel;
        end else if (a == ACC_CTRL_OFFSET) begin
            w[7:0] = s.acc_ctrl;
        end else if (a == ACC_FLAG_OFFSET) begin
            w[OVF_FLAG_BIT] = s.ovf_flag;
            w[IN_FLAG_BIT]  = s.in_flag;
        end else if (a == ACC_COUNT_OFFSET) begin
            w[15:0] = s.acc_count;
        end else if (is_ch_addr(a)) begin
            w[15:0] = s.ch_val[ch_idx(a)];
        end
        return w;
    endfunction : read_word

    // ------------------------------------------------------------------
    // Shared pin front end and clock dividers
    // ------------------------------------------------------------------
    // Accumulator samples the channel 7 pin, synchronised first
    pin_sync_edge u_pin_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .pin_in (channel7_pin),
        .level  (pin_level),
        .rise   (pin_rise),
        .fall   (pin_fall)
    );

    // The divide-by-64 gate clock only runs with the timer enabled
    tick_divider #(.W(DIV64_W)) u_div64 (
        .clk      (clk),
        .rst_n    (rst_n),
        .tick_in  (1'b1),
        .run      (st_ff.timer_en),
        .tick_out (div64_tick)
    );

    tick_divider #(.W(DIV256_W)) u_div256 (
        .clk      (clk),
        .rst_n    (rst_n),
        .tick_in  (acc_inc),
        .run      (accumulator_enable),
        .tick_out (div256_tick)
    );

    tick_divider #(.W(DIV64K_W)) u_div64k (
        .clk      (clk),
        .rst_n    (rst_n),
        .tick_in  (acc_inc),
        .run      (accumulator_enable),
        .tick_out (div64k_tick)
    );

    // ------------------------------------------------------------------
    // Accumulator decode
    // ------------------------------------------------------------------
    // Both modes flag on the same edge: falling when polarity is 0
    assign accumulator_enable       = st_ff.acc_ctrl[ACC_EN_BIT];
    assign gated_mode = st_ff.acc_ctrl[MODE_BIT];
    assign pol        = st_ff.acc_ctrl[POL_BIT];
    assign clk_sel    = st_ff.acc_ctrl[CLK_SEL_HI:CLK_SEL_LO];
    assign sel_edge   = pol ? pin_rise : pin_fall;
    assign gate_open  = pol ? !pin_level : pin_level;
    // Count advance pulse doubles as the accumulator clock
    assign acc_inc    = accumulator_enable && (gated_mode ? (gate_open && div64_tick) : sel_edge);
    assign addr_take  = hsel && hready && htrans[1];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // Data phase write; flag clears come first so a hardware set wins
        if (st_ff.dp_valid && st_ff.dp_write) begin
            if (st_ff.dp_addr == TSC_OFFSET) begin
                nxt_st.timer_en = hwdata[TIMER_EN_BIT];
            end else if (st_ff.dp_addr == FUNC_SEL_OFFSET) begin
                nxt_st.func_sel = hwdata[7:0];
            end else if (st_ff.dp_addr == ACC_CTRL_OFFSET) begin
                nxt_st.acc_ctrl = hwdata[7:0] & ACC_CTRL_MASK;
            end else if (st_ff.dp_addr == ACC_FLAG_OFFSET) begin
                if (st_ff.timer_en || accumulator_enable) begin
                    if (hwdata[OVF_FLAG_BIT]) begin
                        nxt_st.ovf_flag = 1'b0;
                    end
                    if (hwdata[IN_FLAG_BIT]) begin
                        nxt_st.in_flag = 1'b0;
                    end
                end
            end else if (is_ch_addr(st_ff.dp_addr)) begin
                // Capture channels drop the write without effect
                if (st_ff.func_sel[ch_idx(st_ff.dp_addr)]) begin
                    nxt_st.ch_val[ch_idx(st_ff.dp_addr)] = hwdata[15:0];
                end
            end
        end
        // Capture and compare per channel
        for (int i = 0; i < NUM_CH; i++) begin
            if (!st_ff.func_sel[i] && capture_strobe[i]) begin
                nxt_st.ch_val[i] = free_count;
            end
            nxt_st.match[i] = st_ff.func_sel[i] && (free_count == st_ff.ch_val[i]);
        end
        // Accumulator count and flags
        if (acc_inc) begin
            nxt_st.acc_count = st_ff.acc_count + 16'h0001;
            if (st_ff.acc_count == ACC_MAX) begin
                nxt_st.ovf_flag = 1'b1;
            end
        end
        if (accumulator_enable && sel_edge) begin
            nxt_st.in_flag = 1'b1;
        end
        // Interrupt requests gated by their enables
        nxt_st.ovf_irq = st_ff.ovf_flag && st_ff.acc_ctrl[OVF_IE_BIT];
        nxt_st.in_irq  = st_ff.in_flag && st_ff.acc_ctrl[IN_IE_BIT];
        // Counter clock mux follows the select field with no realignment
        if (!accumulator_enable) begin
            nxt_st.cnt_tick = prescaler_tick;
        end else begin
            unique case (clk_sel)
                CLK_PRESCALER: nxt_st.cnt_tick = prescaler_tick;
                CLK_ACC:       nxt_st.cnt_tick = acc_inc;
                CLK_ACC_256:   nxt_st.cnt_tick = div256_tick;
                CLK_ACC_64K:   nxt_st.cnt_tick = div64k_tick;
            endcase
        end
        // Address phase; read data comes from next state so a write lands first
        nxt_st.dp_valid = addr_take;
        nxt_st.dp_write = hwrite;
        nxt_st.dp_addr  = haddr[7:0];
        nxt_st.rdata    = (addr_take && !hwrite) ? read_word(nxt_st, haddr[7:0]) : '0;
        nxt_st.ready    = 1'b1;
        nxt_st.resp     = 1'b0;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= RST_STATE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign hrdata           = st_ff.rdata;
    assign hreadyout        = st_ff.ready;
    assign hresp            = st_ff.resp;
    assign timer_count_tick = st_ff.cnt_tick;
    assign compare_match    = st_ff.match;
    assign timer_enable     = st_ff.timer_en;
    assign ovf_irq_req      = st_ff.ovf_irq;
    assign input_irq_req    = st_ff.in_irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_capture;
        capture_strobe[0] && !st_ff.func_sel[0] |=> st_ff.ch_val[0] == $past(free_count);
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");

    property p_ic_write;
        st_ff.dp_valid && st_ff.dp_write && is_ch_addr(st_ff.dp_addr)
            && !st_ff.func_sel[ch_idx(st_ff.dp_addr)] && capture_strobe == 8'h00
            |=> $stable(st_ff.ch_val);
    endproperty
    a_ic_write: assert property (p_ic_write) else $error("capture value written");

    property p_oc_write;
        st_ff.dp_valid && st_ff.dp_write && st_ff.dp_addr == CH_VAL_BASE && st_ff.func_sel[0]
            |=> st_ff.ch_val[0] == $past(hwdata[15:0]);
    endproperty
    a_oc_write: assert property (p_oc_write) else $error("compare write lost");

    property p_rst_clear;
        $rose(rst_n) |-> st_ff.ch_val == '0;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("channel not cleared");

    property p_off_hold;
        !accumulator_enable |=> $stable(st_ff.acc_count);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("count moved when off");

    property p_event;
        accumulator_enable && !gated_mode && sel_edge |=> st_ff.acc_count == $past(st_ff.acc_count) + 16'h0001;
    endproperty
    a_event: assert property (p_event) else $error("event not counted");

    property p_gated;
        accumulator_enable && gated_mode && !gate_open |=> $stable(st_ff.acc_count);
    endproperty
    a_gated: assert property (p_gated) else $error("closed gate counted");

    property p_div64_off;
        !st_ff.timer_en |=> !div64_tick [*2];
    endproperty
    a_div64_off: assert property (p_div64_off) else $error("div64 ran");

    property p_presc;
        !accumulator_enable |=> timer_count_tick == $past(prescaler_tick);
    endproperty
    a_presc: assert property (p_presc) else $error("wrong clock source");

    property p_acc_src;
        accumulator_enable && clk_sel == CLK_ACC |=> timer_count_tick == $past(acc_inc);
    endproperty
    a_acc_src: assert property (p_acc_src) else $error("acc clock not used");

    property p_ovf;
        acc_inc && st_ff.acc_count == ACC_MAX |=> st_ff.ovf_flag ##1 ovf_irq_req == $past(st_ff.acc_ctrl[OVF_IE_BIT]);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");

    property p_in_irq;
        st_ff.in_flag && !st_ff.acc_ctrl[IN_IE_BIT] |=> !input_irq_req;
    endproperty
    a_in_irq: assert property (p_in_irq) else $error("masked input request");

    c_overflow: cover property (acc_inc && st_ff.acc_count == ACC_MAX);
    c_gated: cover property (accumulator_enable && gated_mode && acc_inc);
    c_capture: cover property (capture_strobe != 8'h00 && st_ff.func_sel == 8'h00);
    c_match: cover property (compare_match != 8'h00);

endmodule : accum_capture_top

// file: verification/pin_source.sv
// Partner model: external pulse and gate source on the shared channel 7 pin
`timescale 1ns/1ps
module pin_source (
    input  wire logic clk,
    output logic      pin
);
    // ------------------------------------------------------------
    // Pin driver
    // ------------------------------------------------------------
    // The pin is always driven by this source, so it never floats
    initial pin = 1'b0;

    // Pulses with w cycles per level, well beyond the two-clock minimum spacing
    task automatic pulses(input int n, input int w);
        repeat (n) begin
            @(posedge clk);
            pin <= 1'b1;
            repeat (w) @(posedge clk);
            pin <= 1'b0;
            repeat (w) @(posedge clk);
        end
    endtask : pulses

    // Holds one level for an exact number of cycles, used as a gate
    task automatic hold(input logic lvl, input int c);
        @(posedge clk);
        pin <= lvl;
        repeat (c) @(posedge clk);
    endtask : hold
endmodule : pin_source

// file: verification/tb_accum_capture_top.sv
// Self-checking testbench for the capture registers and accumulator control
`timescale 1ns/1ps
module tb_accum_capture_top;
    import accum_timer_pkg::*;
    typedef struct {string nm; logic [31:0] v;} note_t;
    logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, channel7_pin;
    logic        prescaler_tick, timer_count_tick, timer_enable, presc_on;
    logic        ovf_irq_req, input_irq_req, rd_dp, obs_vld;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  capture_strobe, compare_match;
    logic [15:0] free_count;
    logic [31:0] haddr, hwdata, hrdata, obs_val, r;
    note_t       exp_q[$];
    note_t       cur;
    int          mismatches, num_checks, tick_cnt, pre_cnt, t0, p0;

    accum_capture_top i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .channel7_pin(channel7_pin), .free_count(free_count),
        .capture_strobe(capture_strobe), .prescaler_tick(prescaler_tick),
        .timer_count_tick(timer_count_tick), .compare_match(compare_match),
        .timer_enable(timer_enable), .ovf_irq_req(ovf_irq_req),
        .input_irq_req(input_irq_req));
    pin_source i_src (.clk(clk), .pin(channel7_pin));

    // ------------------------------------------------------------
    // Clock, counters and result monitor
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Non-blocking so snapshots taken at an edge never race the count
    always @(posedge clk) begin
        if (timer_count_tick === 1'b1) tick_cnt <= tick_cnt + 1;
        if (prescaler_tick) pre_cnt <= pre_cnt + 1;
        prescaler_tick <= presc_on && ($urandom % 2 == 1);
    end

    // Oldest note is matched against each read data phase or observation
    always @(posedge clk) begin
        if ((rd_dp && hreadyout) || obs_vld) begin
            cur = exp_q.pop_front();
            check(cur.nm, rd_dp ? hrdata : obs_val, cur.v);
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
        num_checks++;
        if (seen !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // AHB-Lite master and observation tasks
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input string nm, input logic [31:0] e);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        if (!w) exp_q.push_back('{nm, e});
        rd_dp  <= !w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_dp  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, "", 32'h0);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, nm, e);
    endtask : rd

    task automatic obs(input string nm, input logic [31:0] s, input logic [31:0] e);
        exp_q.push_back('{nm, e});
        obs_val <= s;
        obs_vld <= 1'b1;
        @(posedge clk);
        obs_vld <= 1'b0;
        // Idle edge so a following observation never re-drives the strobe in one step
        @(posedge clk);
    endtask : obs

    // Hang guard, far beyond the fewer than a thousand cycles the tests take
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, hsel, hwrite, htrans, haddr, hwdata, rd_dp, obs_vld} = '0;
        {capture_strobe, free_count, presc_on, prescaler_tick, obs_val} = '0;
        {tick_cnt, pre_cnt, mismatches, num_checks} = '0;
        // Whole words only, so both bytes of a channel value move as one
        hsize = 3'h2;
        void'($urandom(32'h93cf));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, read-write control and an unmapped place
        rd("ctrl reset", ACC_CTRL_OFFSET, 32'h0);
        for (int i = 0; i < NUM_CH; i++) rd("chan reset", CH_VAL_BASE + 8'(4 * i), 32'h0);
        r = $urandom;
        wr(ACC_CTRL_OFFSET, r);
        rd("ctrl rw", ACC_CTRL_OFFSET, {24'h0, r[7:0] & ACC_CTRL_MASK});
        rd("unmapped", 8'h30, 32'h0);
        obs("bus response", {30'h0, hreadyout, hresp}, 32'h2);
        $display("register test done");
        // Compare channels take writes, capture channels ignore them and capture
        wr(FUNC_SEL_OFFSET, 32'h0f);
        r = $urandom;
        wr(CH_VAL_BASE, r);
        wr(CH_VAL_BASE + 8'h04, r);
        rd("chan1 compare", CH_VAL_BASE + 8'h04, {16'h0, r[15:0]});
        wr(CH_VAL_BASE + 8'h14, r);
        rd("chan5 ignored", CH_VAL_BASE + 8'h14, 32'h0);
        // Channels 2 and 3 still hold zero, so they match too when r is zero
        free_count <= r[15:0];
        repeat (3) @(posedge clk);
        obs("compare match", {24'h0, compare_match}, (r[15:0] != 16'h0) ? 32'h03 : 32'h0f);
        wr(FUNC_SEL_OFFSET, 32'h0e);
        free_count     <= r[31:16];
        capture_strobe <= 8'h21;
        @(posedge clk);
        capture_strobe <= 8'h00;
        rd("chan5 capture", CH_VAL_BASE + 8'h14, {16'h0, r[31:16]});
        rd("chan0 capture", CH_VAL_BASE, {16'h0, r[31:16]});
        $display("channel test done");
        // Event mode, rising edges, input interrupt enabled then masked
        wr(ACC_CTRL_OFFSET, 32'h51);
        i_src.pulses(5, 3);
        repeat (6) @(posedge clk);
        rd("count rising", ACC_COUNT_OFFSET, 32'd5);
        rd("edge flag", ACC_FLAG_OFFSET, 32'h1);
        obs("input irq", {31'h0, input_irq_req}, 32'h1);
        obs("overflow irq", {31'h0, ovf_irq_req}, 32'h0);
        wr(ACC_CTRL_OFFSET, 32'h50);
        repeat (2) @(posedge clk);
        obs("input irq masked", {31'h0, input_irq_req}, 32'h0);
        // Falling edges, counter clock taken from the accumulator pulses
        wr(ACC_CTRL_OFFSET, 32'h44);
        t0 = tick_cnt;
        i_src.pulses(3, 3);
        repeat (6) @(posedge clk);
        obs("acc ticks", tick_cnt - t0, 32'd3);
        rd("count falling", ACC_COUNT_OFFSET, 32'd8);
        // Disabled: prescaler drives the counter clock, pin edges are ignored
        wr(ACC_CTRL_OFFSET, 32'h0c);
        presc_on <= 1'b1;
        t0 = tick_cnt;
        p0 = pre_cnt;
        repeat (100) @(posedge clk);
        presc_on <= 1'b0;
        i_src.pulses(2, 3);
        repeat (4) @(posedge clk);
        obs("presc ticks", tick_cnt - t0, pre_cnt - p0);
        rd("count disabled", ACC_COUNT_OFFSET, 32'd8);
        $display("event test done");
        // Gated mode: 256 open cycles give four divide-by-64 counts
        wr(TSC_OFFSET, 32'h80);
        // The enable lands on this edge; sample it once it has settled
        @(posedge clk);
        obs("timer enable", {31'h0, timer_enable}, 32'h1);
        wr(ACC_FLAG_OFFSET, 32'h3);
        rd("flags cleared", ACC_FLAG_OFFSET, 32'h0);
        wr(ACC_CTRL_OFFSET, 32'h60);
        // Pin high for exactly 256 cycles, so the divider phase cannot add a count
        i_src.hold(1'b1, 255);
        i_src.hold(1'b0, 8);
        rd("gated count", ACC_COUNT_OFFSET, 32'd12);
        rd("trailing flag", ACC_FLAG_OFFSET, 32'h1);
        // Timer off: no divide-by-64 clock, so the count must stand still
        wr(TSC_OFFSET, 32'h0);
        i_src.hold(1'b1, 256);
        i_src.hold(1'b0, 8);
        rd("gated no timer", ACC_COUNT_OFFSET, 32'd12);
        $display("gated test done");
        stop_test();
    end
endmodule : tb_accum_capture_top
